// ==== sub_unit_pkg.sv ====
// constants, types and helper functions of the subtract instruction unit
// assumes an 8-bit accumulator core stepped through four phases per instruction
package sub_unit_pkg;
  localparam logic [7:0] OFS_INSTR    = 8'h00;
  localparam logic [7:0] OFS_ACC      = 8'h04;
  localparam logic [7:0] OFS_STATUS   = 8'h08;
  localparam logic [7:0] OFS_STATE    = 8'h0C;
  localparam int         ST_C         = 0;
  localparam int         ST_HALF      = 1;
  localparam int         ST_Z         = 2;
  localparam int         ST_WRAP      = 3;
  localparam int         ST_N         = 4;
  localparam logic [7:0] ACC_RST      = 8'h00;
  localparam logic [7:0] STATUS_RST   = 8'h00;
  localparam logic [15:0] INSTR_RST   = 16'h0000;
  localparam logic [7:0] OPC_IMM      = 8'h08;
  localparam logic [5:0] OPC_REG      = 6'h17;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
  localparam logic [7:0] WIN_SPLIT    = 8'h80;
  localparam logic [3:0] WIN_LOW_BANK = 4'h0;
  localparam logic [3:0] WIN_HIGH_BANK = 4'hF;

  typedef enum logic [2:0] {
    PH_IDLE    = 3'b000,
    PH_DECODE  = 3'b001,
    PH_READ    = 3'b010,
    PH_PROCESS = 3'b011,
    PH_WRITE   = 3'b100
  } phase_type;

  // returns {sign, signed wrap, zero, half borrow, borrow_inv, difference} of a - w
  function automatic logic [12:0] sub_calc(input logic [7:0] a, input logic [7:0] w);
    logic [7:0] d;
    d = 8'(a - w);
    sub_calc = {d[7], (a[7] ^ w[7]) & (d[7] ^ a[7]), d == 8'h00,
                a[3:0] >= w[3:0], a >= w, d};
  endfunction : sub_calc

  function automatic logic is_sub_word(input logic [15:0] w);
    is_sub_word = (w[15:8] == OPC_IMM) || (w[15:10] == OPC_REG);
  endfunction : is_sub_word

  function automatic logic reg_known(input logic [7:0] a);
    reg_known = (a == OFS_INSTR) || (a == OFS_ACC) || (a == OFS_STATUS) || (a == OFS_STATE);
  endfunction : reg_known
endpackage : sub_unit_pkg

// ==== sub_instr_unit.sv ====
// subtract instruction unit: four-phase sequencer, flag logic, AXI4-Lite registers
// assumes the banked data memory answers mem_rdata combinationally from mem_addr
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ns
module sub_instr_unit
(
  input  wire logic        aclk,          // core clock
  input  wire logic        aresetn,       // synchronous reset
  input  wire logic [7:0]  s_axi_awaddr,  // write address
  input  wire logic        s_axi_awvalid, // write address valid
  output logic             s_axi_awready, // write address ready
  input  wire logic [31:0] s_axi_wdata,   // write data
  input  wire logic [3:0]  s_axi_wstrb,   // write strobes
  input  wire logic        s_axi_wvalid,  // write data valid
  output logic             s_axi_wready,  // write data ready
  output logic [1:0]       s_axi_bresp,   // write response
  output logic             s_axi_bvalid,  // write response valid
  input  wire logic        s_axi_bready,  // write response ready
  input  wire logic [7:0]  s_axi_araddr,  // read address
  input  wire logic        s_axi_arvalid, // read address valid
  output logic             s_axi_arready, // read address ready
  output logic [31:0]      s_axi_rdata,   // read data
  output logic [1:0]       s_axi_rresp,   // read response
  output logic             s_axi_rvalid,  // read data valid
  input  wire logic        s_axi_rready,  // read data ready
  input  wire logic [3:0]  bank_pointer,  // current bank
  output logic [11:0]      mem_addr,      // data memory address
  input  wire logic [7:0]  mem_rdata,     // data memory read value
  output logic [7:0]       mem_wdata,     // data memory write value
  output logic             mem_we,        // data memory write strobe
  output logic             busy           // instruction under way
);
  import sub_unit_pkg::*;

  phase_type   phase_r;
  logic [15:0] instr_r;
  logic [7:0]  acc_r;
  logic [7:0]  status_r;
  logic [7:0]  status_nxt;
  logic        is_reg_r;
  logic        dest_r;
  logic [7:0]  operand_r;
  logic [7:0]  result_r;
  logic [4:0]  flags_r;
  logic [12:0] calc;
  logic [11:0] mem_addr_r;
  logic [7:0]  mem_wdata_r;
  logic        mem_we_r;
  logic        aw_held_r;
  logic        w_held_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic        wr_fire;
  logic        start;
  logic        sw_wr_ok;

  assign s_axi_awready = !aw_held_r;
  assign s_axi_wready  = !w_held_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign mem_addr      = mem_addr_r;
  assign mem_wdata     = mem_wdata_r;
  assign mem_we        = mem_we_r;
  assign busy          = phase_r != PH_IDLE;

  assign wr_fire  = aw_held_r && w_held_r && !bvalid_r;
  assign sw_wr_ok = wr_fire && (phase_r == PH_IDLE);
  // only a complete low halfword holding a subtract opcode starts the sequencer
  assign start    = sw_wr_ok && (awaddr_r == OFS_INSTR) && (wstrb_r[1:0] == 2'b11)
                    && is_sub_word(wdata_r[15:0]);
  assign calc     = sub_calc(operand_r, acc_r);

  // write address and data are taken independently
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      awaddr_r  <= 8'h00;
    end
    else if (s_axi_awvalid && !aw_held_r)
    begin
      aw_held_r <= 1'b1;
      awaddr_r  <= s_axi_awaddr;
    end
    else if (wr_fire)
      aw_held_r <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_r <= 1'b0;
      wdata_r  <= 32'h00000000;
      wstrb_r  <= 4'h0;
    end
    else if (s_axi_wvalid && !w_held_r)
    begin
      w_held_r <= 1'b1;
      wdata_r  <= s_axi_wdata;
      wstrb_r  <= s_axi_wstrb;
    end
    else if (wr_fire)
      w_held_r <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_r <= 1'b1;
      bresp_r  <= (reg_known(awaddr_r) && awaddr_r != OFS_STATE) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_r <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h00000000;
      rresp_r  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && !rvalid_r)
    begin
      rvalid_r <= 1'b1;
      rresp_r  <= reg_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        OFS_INSTR:  rdata_r <= {16'h0000, instr_r};
        OFS_ACC:    rdata_r <= {24'h000000, acc_r};
        OFS_STATUS: rdata_r <= {24'h000000, status_r};
        OFS_STATE:  rdata_r <= {28'h0000000, busy, phase_r};
        default:    rdata_r <= 32'h00000000;
      endcase
    end
    else if (s_axi_rready)
      rvalid_r <= 1'b0;
  end

  // four-phase sequencer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      phase_r <= PH_IDLE;
    else
    begin
      case (phase_r)
        PH_IDLE:    phase_r <= start ? PH_DECODE : PH_IDLE;
        PH_DECODE:  phase_r <= PH_READ;
        PH_READ:    phase_r <= PH_PROCESS;
        PH_PROCESS: phase_r <= PH_WRITE;
        PH_WRITE:   phase_r <= PH_IDLE;
        default:    phase_r <= PH_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      instr_r <= INSTR_RST;
    else if (start)
      instr_r <= wdata_r[15:0];
  end

  // decode: kind, destination and memory address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      is_reg_r   <= 1'b0;
      dest_r     <= 1'b0;
      mem_addr_r <= 12'h000;
    end
    else if (phase_r == PH_DECODE)
    begin
      is_reg_r <= instr_r[15:10] == OPC_REG;
      dest_r   <= instr_r[9];
      if (instr_r[8])
        mem_addr_r <= {bank_pointer, instr_r[7:0]};
      else if (instr_r[7:0] < WIN_SPLIT)
        mem_addr_r <= {WIN_LOW_BANK, instr_r[7:0]};
      else
        mem_addr_r <= {WIN_HIGH_BANK, instr_r[7:0]};
    end
  end

  // read: register value or literal
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      operand_r <= 8'h00;
    else if (phase_r == PH_READ)
      operand_r <= is_reg_r ? mem_rdata : instr_r[7:0];
  end

  // process: difference and flags
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      result_r    <= 8'h00;
      flags_r     <= 5'h00;
      mem_wdata_r <= 8'h00;
      mem_we_r    <= 1'b0;
    end
    else
    begin
      mem_we_r <= (phase_r == PH_PROCESS) && is_reg_r && dest_r;
      if (phase_r == PH_PROCESS)
      begin
        result_r    <= calc[7:0];
        flags_r     <= calc[12:8];
        mem_wdata_r <= calc[7:0];
      end
    end
  end

  always_comb
  begin
    status_nxt          = status_r;
    status_nxt[ST_C]    = flags_r[0];
    status_nxt[ST_HALF] = flags_r[1];
    status_nxt[ST_Z]    = flags_r[2];
    status_nxt[ST_WRAP] = flags_r[3];
    status_nxt[ST_N]    = flags_r[4];
  end

  // write destination; software writes only while idle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      acc_r <= ACC_RST;
    else if (phase_r == PH_WRITE && !(is_reg_r && dest_r))
      acc_r <= result_r;
    else if (sw_wr_ok && awaddr_r == OFS_ACC && wstrb_r[0])
      acc_r <= wdata_r[7:0];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      status_r <= STATUS_RST;
    else if (phase_r == PH_WRITE)
      status_r <= status_nxt;
    else if (sw_wr_ok && awaddr_r == OFS_STATUS && wstrb_r[0])
      status_r <= wdata_r[7:0];
  end

  property p_phase_order;
    @(posedge aclk) disable iff (!aresetn)
    phase_r == PH_DECODE |=> phase_r == PH_READ ##1 phase_r == PH_PROCESS
      ##1 phase_r == PH_WRITE ##1 phase_r == PH_IDLE;
  endproperty
  a_phase_order: assert property (p_phase_order) else $error("phase order broken");

  property p_decode_gate;
    @(posedge aclk) disable iff (!aresetn)
    (phase_r == PH_IDLE && !start) |=> phase_r == PH_IDLE;
  endproperty
  a_decode_gate: assert property (p_decode_gate) else $error("started without a subtract word");

  property p_imm_result;
    @(posedge aclk) disable iff (!aresetn)
    (phase_r == PH_READ && !is_reg_r) |=> ##2 acc_r == 8'($past(instr_r[7:0], 2) - $past(acc_r, 2));
  endproperty
  a_imm_result: assert property (p_imm_result) else $error("literal difference wrong");

  property p_reg_writeback;
    @(posedge aclk) disable iff (!aresetn)
    (phase_r == PH_PROCESS && is_reg_r && dest_r) |=>
      mem_we_r && mem_wdata_r == 8'($past(operand_r) - $past(acc_r)) ##1 !mem_we_r && $stable(acc_r);
  endproperty
  a_reg_writeback: assert property (p_reg_writeback) else $error("register write-back wrong");

  property p_reg_to_acc;
    @(posedge aclk) disable iff (!aresetn)
    (phase_r == PH_WRITE && is_reg_r && !dest_r) |-> !mem_we_r ##1 acc_r == $past(result_r);
  endproperty
  a_reg_to_acc: assert property (p_reg_to_acc) else $error("accumulator target wrong");

  property p_bank_select;
    @(posedge aclk) disable iff (!aresetn)
    (phase_r == PH_DECODE) |=> mem_addr_r == (instr_r[8] ? {$past(bank_pointer), instr_r[7:0]} :
      {(instr_r[7:0] < WIN_SPLIT) ? WIN_LOW_BANK : WIN_HIGH_BANK, instr_r[7:0]});
  endproperty
  a_bank_select: assert property (p_bank_select) else $error("bank selection wrong");

  property p_keep_bits;
    @(posedge aclk) disable iff (!aresetn)
    phase_r == PH_WRITE |=> status_r[7:5] == $past(status_r[7:5]);
  endproperty
  a_keep_bits: assert property (p_keep_bits) else $error("unrelated status bits changed");

  property p_carry_zero;
    @(posedge aclk) disable iff (!aresetn)
    phase_r == PH_PROCESS |=> ##1 status_r[ST_C] == ($past(operand_r, 2) >= $past(acc_r, 2))
      && status_r[ST_Z] == ($past(operand_r, 2) == $past(acc_r, 2));
  endproperty
  a_carry_zero: assert property (p_carry_zero) else $error("carry or zero flag wrong");

  property p_sign_wrap;
    @(posedge aclk) disable iff (!aresetn)
    phase_r == PH_WRITE |=> status_r[ST_N] == $past(result_r[7]) && status_r[ST_WRAP] ==
      (($past(operand_r[7]) ^ $past(acc_r[7])) & ($past(result_r[7]) ^ $past(operand_r[7])));
  endproperty
  a_sign_wrap: assert property (p_sign_wrap) else $error("sign or overflow flag wrong");

  property p_half_borrow;
    @(posedge aclk) disable iff (!aresetn)
    phase_r == PH_WRITE |=> status_r[ST_HALF] == ($past(operand_r[3:0]) >= $past(acc_r[3:0]));
  endproperty
  a_half_borrow: assert property (p_half_borrow) else $error("half borrow flag wrong");
endmodule : sub_instr_unit

// ==== bank_mem_model.sv ====
// banked data memory seen by the subtract unit: 16 banks of 256 bytes
// assumes mem_addr is {bank, offset}; reads are combinational, writes land on the rising edge
`timescale 1ns/1ns
module bank_mem_model
(
  input  wire logic        aclk,      // core clock
  input  wire logic [11:0] mem_addr,  // bank and offset
  output logic [7:0]       mem_rdata, // read value
  input  wire logic [7:0]  mem_wdata, // write value
  input  wire logic        mem_we     // write strobe
);
  logic [7:0] cells [4096];

  assign mem_rdata = cells[mem_addr];

  // plain always so the bench may preload cells between edges
  always @(posedge aclk)
  begin
    if (mem_we)
      cells[mem_addr] <= mem_wdata;
  end
endmodule : bank_mem_model

// ==== testbench.sv ====
// self-checking bench: AXI4-Lite tasks drive both subtract instructions
// assumes the unit answers on AXI4-Lite and the memory model stands on its data port
`timescale 1ns/1ns
module testbench;
  import sub_unit_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready = 1'b0;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready = 1'b0;
  logic [3:0]  bank_pointer = 4'h0;
  logic [11:0] mem_addr;
  logic [7:0]  mem_rdata;
  logic [7:0]  mem_wdata;
  logic        mem_we;
  logic        busy;
  logic [1:0]  rsp;
  logic [31:0] rd;
  int          failures = 0;
  int          compares = 0;
  int          we_at;
  int          idle_at;

  always #25 aclk = ~aclk;

  sub_instr_unit dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .bank_pointer(bank_pointer), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .mem_wdata(mem_wdata), .mem_we(mem_we), .busy(busy));

  bank_mem_model mem_u (.aclk(aclk), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .mem_wdata(mem_wdata), .mem_we(mem_we));

  task automatic tally_and_finish;
    if (failures == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic give_up;
    failures++;
    tally_and_finish();
  endtask : give_up

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!(s_axi_bready && s_axi_bvalid) && n < 50);
    if (n >= 50)
      give_up();
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid && n < 50);
    if (n >= 50)
      give_up();
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  // loads accumulator and status, starts one word, counts edges to the write strobe and to idle
  task automatic run(input logic [15:0] ins, input logic [7:0] acc, input logic [7:0] st);
    int n;
    axi_wr(OFS_ACC, {24'h0, acc}, rsp);
    axi_wr(OFS_STATUS, {24'h0, st}, rsp);
    axi_wr(OFS_INSTR, {16'h0, ins}, rsp);
    n = 0;
    we_at = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (mem_we === 1'b1)
        we_at = n;
    end
    while (busy !== 1'b0 && n < 20);
    if (busy !== 1'b0)
      give_up();
    idle_at = n;
  endtask : run

  // expected status: kept bits 7:5, then sign, overflow, zero, half borrow, borrow
  function automatic logic [7:0] flags(input logic [7:0] a, input logic [7:0] w, input logic [7:0] k);
    logic [7:0] d;
    d = a - w;
    flags = {k[7:5], d[7], (a[7] != w[7]) && (d[7] != a[7]), d == 8'h00, a[3:0] >= w[3:0], a >= w};
  endfunction : flags

  logic [7:0] lit_t [5] = '{8'h02, 8'h02, 8'h02, 8'h80, 8'h10};
  logic [7:0] acc_t [5] = '{8'h01, 8'h02, 8'h03, 8'h01, 8'h01};

  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      run({OPC_IMM, lit_t[i]}, acc_t[i], 8'hE0);
      chk(32'(idle_at), 32'd4);
      axi_rd(OFS_ACC, rd, rsp);
      chk(rd, {24'h0, 8'(lit_t[i] - acc_t[i])});
      axi_rd(OFS_STATUS, rd, rsp);
      chk(rd, {24'h0, flags(lit_t[i], acc_t[i], 8'hE0)});
    end
    // banked read through the pointer, result to the accumulator
    bank_pointer <= 4'h5;
    mem_u.cells[12'h510] = 8'h03;
    run(16'h5D10, 8'h02, 8'h00);
    chk({30'h0, rsp}, {30'h0, RESP_OKAY});
    axi_rd(OFS_ACC, rd, rsp);
    chk(rd, 32'h1);
    chk({30'h0, rsp}, {30'h0, RESP_OKAY});
    chk({24'h0, mem_u.cells[12'h510]}, 32'h3);
    chk(32'(we_at), 32'd0);
    axi_rd(OFS_STATUS, rd, rsp);
    chk(rd, 32'h3);
    // shared window above the split maps to the high bank; pointer ignored
    mem_u.cells[12'hF90] = 8'h01;
    mem_u.cells[12'h590] = 8'h33;
    run(16'h5E90, 8'h02, 8'h00);
    chk(32'(we_at), 32'd3);
    chk(32'(idle_at), 32'd4);
    chk({24'h0, mem_u.cells[12'hF90]}, 32'hFF);
    chk({24'h0, mem_u.cells[12'h590]}, 32'h33);
    axi_rd(OFS_ACC, rd, rsp);
    chk(rd, 32'h2);
    axi_rd(OFS_STATUS, rd, rsp);
    chk(rd, 32'h10);
    axi_rd(OFS_INSTR, rd, rsp);
    chk(rd, 32'h5E90);
    axi_rd(OFS_STATE, rd, rsp);
    chk(rd, 32'h0);
    // borrow-subtract opcode is not decoded here: nothing starts, accumulator kept
    run(16'h5910, 8'h07, 8'h00);
    chk(32'(idle_at), 32'd1);
    axi_rd(OFS_ACC, rd, rsp);
    chk(rd, 32'h7);
    axi_rd(OFS_INSTR, rd, rsp);
    chk(rd, 32'h5E90);
    // refused accesses
    axi_rd(8'hF0, rd, rsp);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    axi_wr(OFS_STATE, 32'h0, rsp);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    tally_and_finish();
  end
endmodule : testbench
